// [core/ibx_pkg.sv]
// Shared types and constants for the increment, OR and jump execute block
package ibx_pkg;
	localparam int DATA_W    = 8;
	localparam int FILE_AW   = 7;
	localparam int FILE_DEPTH = 128;
	localparam int IMM_W     = 11;
	localparam int PC_W      = 13;
	localparam int LATCH_W   = 8;
	localparam int LATCH_HI  = 4;
	localparam int LATCH_LO  = 3;
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [DATA_W-1:0] ONE      = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
	localparam logic [FILE_AW-1:0] ADDR_RST = 7'h00;

	typedef enum logic [2:0] {
		IBX_INCREMENT_FILE,
		IBX_INCREMENT_SKIP_IF_ZERO,
		IBX_OR_LITERAL_INTO_ACCUMULATOR,
		IBX_OR_ACCUMULATOR_WITH_FILE,
		IBX_JUMP_IMMEDIATE
	} ibx_op_t;

	typedef struct packed {
		ibx_op_t            op;
		logic [FILE_AW-1:0] file_addr;
		logic               dest;
		logic [IMM_W-1:0]   imm;
	} ibx_instr_t;
endpackage

// [core/ibx_file_mem.sv]
// File register array with a registered read port
module ibx_file_mem #(
	parameter int DEPTH = 128,
	parameter int AW    = 7,
	parameter int W     = 8
) (
	input  wire logic          sys_clk_in,
	input  wire logic          arst_n_in,
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [W-1:0]  wr_data_in,
	input  wire logic          rd_en_in,
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [W-1:0]  rd_data_out
);
	logic [W-1:0] mem_r [DEPTH];

	// No reset on the array keeps it mappable to plain RAM
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= mem_r[rd_addr_in];
		end
	end
endmodule

// [core/ibx_exec.sv]
// Execute unit for increment, increment-skip, OR and jump instructions
// What this block does
// - Destination bit picks accumulator or file
// - Increment file, route sum, update zero
// - Increment-skip stores sum, flags untouched
// - Zero result turns next instruction into nop
// - Nonzero result runs next instruction normally
// - Jump loads eleven-bit immediate into pc low
// - Pc bits 12:11 from latch bits 4:3
// - Jump unconditional, no flags, two cycles
// - Or literal into accumulator, update zero
// - Or accumulator with file, update zero
module ibx_exec (
	input  wire logic                          sys_clk_in,
	input  wire logic                          arst_n_in,
	input  wire logic                          instr_valid_in,
	input  wire ibx_pkg::ibx_instr_t           instr_in,
	input  wire logic [ibx_pkg::LATCH_W-1:0]   pc_high_latch_in,
	output logic                               ready_out,
	output logic                               done_out,
	output logic                               nop_out,
	output logic [ibx_pkg::DATA_W-1:0]         acc_out,
	output logic                               zero_out,
	output logic [ibx_pkg::PC_W-1:0]           pc_out,
	output logic                               pc_load_out,
	output logic                               file_we_out,
	output logic [ibx_pkg::FILE_AW-1:0]        file_addr_out,
	output logic [ibx_pkg::DATA_W-1:0]         file_data_out
);
	import ibx_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE,
		S_READ,
		S_JUMP
	} ibx_state_t;

	ibx_state_t        state_r;
	ibx_instr_t        ins_r;
	logic              skip_r;
	logic [DATA_W-1:0] mem_rdata;
	logic [DATA_W-1:0] result;
	logic [DATA_W-1:0] lit_or;
	logic [PC_W-1:0]   jump_target;
	logic              accept;
	logic              exec;
	logic              res_zero;
	logic              lit_zero;

	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return v == ZERO_VAL;
	endfunction

	assign accept      = (state_r == S_IDLE) && instr_valid_in;
	assign exec        = (state_r == S_READ);
	assign lit_or      = acc_out | instr_in.imm[DATA_W-1:0];
	assign lit_zero    = is_zero(lit_or);
	assign jump_target = {pc_high_latch_in[LATCH_HI:LATCH_LO], instr_in.imm};
	assign res_zero    = is_zero(result);

	always_comb begin
		case (ins_r.op)
			IBX_OR_ACCUMULATOR_WITH_FILE: result = acc_out | mem_rdata;
			IBX_INCREMENT_FILE:           result = mem_rdata + ONE;
			IBX_INCREMENT_SKIP_IF_ZERO:   result = mem_rdata + ONE;
			default:                      result = mem_rdata;
		endcase
	end

	// Operand is read at acceptance, so a file op costs one extra cycle
	ibx_file_mem #(
		.DEPTH (FILE_DEPTH),
		.AW    (FILE_AW),
		.W     (DATA_W)
	) u_mem (
		.sys_clk_in  (sys_clk_in),
		.arst_n_in   (arst_n_in),
		.wr_en_in    (exec && ins_r.dest == DEST_FILE),
		.wr_addr_in  (ins_r.file_addr),
		.wr_data_in  (result),
		.rd_en_in    (accept),
		.rd_addr_in  (instr_in.file_addr),
		.rd_data_out (mem_rdata)
	);

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r   <= S_IDLE;
			ready_out <= 1'b1;
			ins_r     <= '0;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (accept && !skip_r) begin
						ins_r <= instr_in;
						if (instr_in.op == IBX_JUMP_IMMEDIATE) begin
							state_r   <= S_JUMP;
							ready_out <= 1'b0;
						end else if (instr_in.op != IBX_OR_LITERAL_INTO_ACCUMULATOR) begin
							state_r   <= S_READ;
							ready_out <= 1'b0;
						end
					end
				end
				S_READ: begin
					state_r   <= S_IDLE;
					ready_out <= 1'b1;
				end
				S_JUMP: begin
					state_r   <= S_IDLE;
					ready_out <= 1'b1;
				end
				default: begin
					state_r   <= S_IDLE;
					ready_out <= 1'b1;
				end
			endcase
		end
	end

	// Skip is armed here and spent on the next accepted instruction
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			skip_r <= 1'b0;
		end else if (exec && ins_r.op == IBX_INCREMENT_SKIP_IF_ZERO) begin
			skip_r <= res_zero;
		end else if (accept && skip_r) begin
			skip_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_out  <= ACC_RST;
			zero_out <= 1'b0;
		end else if (accept && !skip_r && instr_in.op == IBX_OR_LITERAL_INTO_ACCUMULATOR) begin
			acc_out  <= lit_or;
			zero_out <= lit_zero;
		end else if (exec) begin
			if (ins_r.dest == DEST_ACC) begin
				acc_out <= result;
			end
			if (ins_r.op != IBX_INCREMENT_SKIP_IF_ZERO) begin
				zero_out <= res_zero;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			file_we_out   <= 1'b0;
			file_addr_out <= ADDR_RST;
			file_data_out <= ZERO_VAL;
		end else begin
			file_we_out <= exec && ins_r.dest == DEST_FILE;
			if (exec) begin
				file_addr_out <= ins_r.file_addr;
				file_data_out <= result;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pc_out      <= PC_RST;
			pc_load_out <= 1'b0;
			done_out    <= 1'b0;
			nop_out     <= 1'b0;
		end else begin
			if (accept && !skip_r && instr_in.op == IBX_JUMP_IMMEDIATE) begin
				pc_out <= jump_target;
			end
			pc_load_out <= (state_r == S_JUMP);
			nop_out     <= accept && skip_r;
			done_out    <= exec || (state_r == S_JUMP) ||
				(accept && !skip_r && instr_in.op == IBX_OR_LITERAL_INTO_ACCUMULATOR);
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_jump_taken;
		accept && !skip_r && instr_in.op == IBX_JUMP_IMMEDIATE;
	endsequence

	sequence s_jump_finish;
		!ready_out && !done_out ##1 pc_load_out && done_out && ready_out;
	endsequence

	a_jump_two_cycle: assert property (s_jump_taken |=> s_jump_finish)
		else $error("jump did not finish in two cycles");
	a_jump_target: assert property (s_jump_taken |=> pc_out == $past(jump_target))
		else $error("jump target wrong");
	a_jump_flags: assert property (s_jump_taken |-> ##2 zero_out == $past(zero_out, 2))
		else $error("jump changed zero flag");
	a_pc_hold: assert property (
		!(accept && !skip_r && instr_in.op == IBX_JUMP_IMMEDIATE) |=> $stable(pc_out))
		else $error("program counter moved without a jump");

	// A file op holds ready low for exactly one cycle while the operand is read
	sequence s_file_taken;
		accept && !skip_r && instr_in.op != IBX_JUMP_IMMEDIATE &&
			instr_in.op != IBX_OR_LITERAL_INTO_ACCUMULATOR;
	endsequence

	sequence s_file_finish;
		!ready_out && !done_out ##1 ready_out && done_out;
	endsequence

	a_file_two_cycle: assert property (s_file_taken |=> s_file_finish)
		else $error("file operation did not finish in two cycles");
	a_skip_discard: assert property (
		accept && skip_r |=> nop_out && !done_out && $stable(acc_out))
		else $error("skipped instruction was not discarded");
	a_skip_arm: assert property (
		exec && ins_r.op == IBX_INCREMENT_SKIP_IF_ZERO |=> skip_r == $past(res_zero))
		else $error("skip arming wrong");
	a_skip_release: assert property (
		exec && ins_r.op == IBX_INCREMENT_SKIP_IF_ZERO && !res_zero |=> !skip_r ##1 !nop_out)
		else $error("nonzero increment-skip armed a skip");
	a_skip_flags: assert property (
		exec && ins_r.op == IBX_INCREMENT_SKIP_IF_ZERO |=> $stable(zero_out))
		else $error("increment-skip touched zero flag");
	a_zero_update: assert property (
		exec && ins_r.op != IBX_INCREMENT_SKIP_IF_ZERO |=> zero_out == $past(res_zero))
		else $error("zero flag not updated from result");
	a_dest_acc: assert property (
		exec && ins_r.dest == DEST_ACC |=> acc_out == $past(result) && !file_we_out)
		else $error("accumulator destination wrong");
	a_dest_file: assert property (
		exec && ins_r.dest == DEST_FILE |=> file_we_out &&
			file_data_out == $past(result) &&
			file_addr_out == $past(ins_r.file_addr) &&
			$stable(acc_out))
		else $error("file destination wrong");
	a_lit_or: assert property (
		accept && !skip_r && instr_in.op == IBX_OR_LITERAL_INTO_ACCUMULATOR |=>
			acc_out == $past(lit_or) && zero_out == $past(lit_zero) && done_out)
		else $error("literal or result wrong");
endmodule

// [bench/ibx_exec_test.sv]
// Self-checking testbench for the increment, OR and jump execute unit
module ibx_exec_test;
	timeunit 1ns;
	timeprecision 100ps;
	import ibx_pkg::*;
	logic              sys_clk_in;
	logic              arst_n_in;
	logic              instr_valid_in;
	ibx_instr_t        instr_in;
	logic [7:0]        pc_high_latch_in;
	logic              ready_out;
	logic              done_out;
	logic              nop_out;
	logic [7:0]        acc_out;
	logic              zero_out;
	logic [12:0]       pc_out;
	logic              pc_load_out;
	logic              file_we_out;
	logic [6:0]        file_addr_out;
	logic [7:0]        file_data_out;
	int                err_total;
	int                n_compared;
	ibx_exec u_ibx_exec (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.pc_high_latch_in(pc_high_latch_in), .ready_out(ready_out), .done_out(done_out),
		.nop_out(nop_out), .acc_out(acc_out), .zero_out(zero_out), .pc_out(pc_out),
		.pc_load_out(pc_load_out), .file_we_out(file_we_out),
		.file_addr_out(file_addr_out), .file_data_out(file_data_out));
	initial begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	// Waits for ready, then holds the request up to and including the accepting edge
	task automatic issue(input ibx_op_t op, input logic [6:0] a, input logic d,
		input logic [10:0] k, input logic [7:0] lat);
		int i;
		i = 0;
		while (ready_out !== 1'b1 && i < 20) begin
			wt(1);
			i++;
		end
		if (i == 20) begin
			err_total++;
			finish_test();
		end else begin
			@(posedge sys_clk_in);
			instr_valid_in <= 1'b1;
			instr_in <= '{op: op, file_addr: a, dest: d, imm: k};
			pc_high_latch_in <= lat;
			@(posedge sys_clk_in);
			instr_valid_in <= 1'b0;
			#1;
		end
	endtask
	// Returns one step after the accepting edge, while the one-cycle answer stands
	task automatic lit(input logic [10:0] k);
		issue(IBX_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, k, 8'h00);
	endtask
	// File ops block the next request for exactly one cycle
	task automatic fop(input ibx_op_t op, input logic [6:0] a, input logic d);
		issue(op, a, d, 11'h000, 8'h00);
		chk(ready_out, 16'h0000);
		wt(1);
		chk({ready_out, done_out}, 16'h0003);
	endtask
	task automatic t_or_lit();
		lit(11'h700);
		chk({done_out, acc_out}, 16'h0100);
		chk(zero_out, 16'h0001);
		lit(11'h05a);
		chk({done_out, acc_out}, 16'h015a);
		chk(zero_out, 16'h0000);
		lit(11'h0a5);
		chk({done_out, acc_out}, 16'h01ff);
		$display("or literal test done");
	endtask
	task automatic t_file();
		fop(IBX_OR_ACCUMULATOR_WITH_FILE, 7'h7f, DEST_FILE);
		chk({file_we_out, file_addr_out, file_data_out}, 16'hffff);
		chk({acc_out, 7'h00, zero_out}, 16'hff00);
		fop(IBX_INCREMENT_FILE, 7'h7f, DEST_FILE);
		chk({file_we_out, file_data_out}, 16'h0100);
		chk({acc_out, 7'h00, zero_out}, 16'hff01);
		fop(IBX_INCREMENT_FILE, 7'h7f, DEST_ACC);
		chk({file_we_out, acc_out, zero_out}, 16'h0002);
		$display("file op test done");
	endtask
	task automatic t_skip();
		lit(11'h0ff);
		fop(IBX_OR_ACCUMULATOR_WITH_FILE, 7'h7f, DEST_FILE);
		fop(IBX_INCREMENT_FILE, 7'h7f, DEST_ACC);
		fop(IBX_INCREMENT_SKIP_IF_ZERO, 7'h7f, DEST_FILE);
		chk({file_we_out, file_data_out}, 16'h0100);
		chk(zero_out, 16'h0001);
		lit(11'h001);
		chk({ready_out, nop_out, done_out, acc_out}, 16'h0600);
		fop(IBX_INCREMENT_SKIP_IF_ZERO, 7'h7f, DEST_ACC);
		chk({acc_out, zero_out}, 16'h0003);
		lit(11'h002);
		chk({nop_out, done_out, acc_out, zero_out}, 16'h0206);
		$display("skip test done");
	endtask
	task automatic jmp(input logic [10:0] k, input logic [7:0] lat, input logic [12:0] exp);
		issue(IBX_JUMP_IMMEDIATE, 7'h00, 1'b0, k, lat);
		chk(pc_out, exp);
		chk({ready_out, pc_load_out, done_out}, 16'h0000);
		wt(1);
		chk({pc_load_out, done_out, zero_out}, 16'h0006);
	endtask
	task automatic t_jump();
		jmp(11'h7ff, 8'h18, 13'h1fff);
		jmp(11'h555, 8'he7, 13'h0555);
		jmp(11'h000, 8'h08, 13'h0800);
		$display("jump test done");
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		err_total++;
		finish_test();
	end
	initial begin
		err_total = 0;
		n_compared = 0;
		arst_n_in = 1'b0;
		instr_valid_in = 1'b0;
		instr_in = '0;
		pc_high_latch_in = 8'h00;
		repeat (5) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		wt(1);
		chk({ready_out, done_out, acc_out, zero_out}, 16'h0400);
		chk(pc_out, 13'h0000);
		t_or_lit();
		t_file();
		t_skip();
		t_jump();
		finish_test();
	end
endmodule
